// file: core/pps_params.svh
// Timing counts, thresholds and reset values of the power sequencer.
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_CLK_MHZ            50
`define PPS_TICK_US            1000
`define PPS_TICK_CYCLES        (`PPS_TICK_US * `PPS_CLK_MHZ)
`define PPS_RESET_DELAY_MS     65
`define PPS_RESET_DELAY_TICKS  ((`PPS_RESET_DELAY_MS * 1000) / `PPS_TICK_US)
`define PPS_DEBOUNCE_MS        10
`define PPS_DEBOUNCE_TICKS     ((`PPS_DEBOUNCE_MS * 1000) / `PPS_TICK_US)
`define PPS_TRICKLE_TIMEOUT_H  1
`define PPS_CCCV_TIMEOUT_H     3
`define PPS_TICKS_PER_HOUR     ((64'd3600 * 1000000) / `PPS_TICK_US)
`define PPS_TRICKLE_TICKS      (`PPS_TRICKLE_TIMEOUT_H * `PPS_TICKS_PER_HOUR)
`define PPS_CCCV_TICKS         (`PPS_CCCV_TIMEOUT_H * `PPS_TICKS_PER_HOUR)
`define PPS_TRICKLE_PCT        12
`define PPS_SCALE_RESET_PCT    100
`define PPS_SCALE_MIN_PCT      40
`define PPS_SCALE_MAX_PCT      180
`define PPS_CURRENT_MIN_MA     100
`define PPS_CURRENT_MAX_MA     1000
`define PPS_USB_FIXED_MA       100
`define PPS_TERM_STEP_PCT      5
`endif

// file: core/pps_pkg.sv
// Types and shared arithmetic of the power sequencer.
package pps_pkg;

    typedef enum logic [2:0] {
        PPS_SEQ_OFF     = 3'b000,
        PPS_SEQ_BUCK_UP = 3'b001,
        PPS_SEQ_DIG_UP  = 3'b010,
        PPS_SEQ_RESET   = 3'b011,
        PPS_SEQ_RUN     = 3'b100
    } pps_seq_t;

    typedef enum logic [2:0] {
        PPS_CHG_IDLE    = 3'b000,
        PPS_CHG_TRICKLE = 3'b001,
        PPS_CHG_CC      = 3'b010,
        PPS_CHG_CV      = 3'b011,
        PPS_CHG_SLEEP   = 3'b100,
        PPS_CHG_FAULT   = 3'b101
    } pps_chg_mode_t;

    typedef struct packed {
        logic       adapter_above_uvlo;
        logic       key_n;
        logic       hold;
        logic       test_enable;
        logic       source_select;
        logic       force_battery;
        logic       buck_good;
        logic       digital_good;
        logic [3:0] aux_request;
    } pps_sense_t;

    typedef struct packed {
        logic        charger_enable_n;
        logic        batt_above_precond;
        logic        batt_at_regulation;
        logic        current_below_term;
        logic        batt_below_recharge;
        logic [10:0] charge_current_set_default_ma;
        logic [7:0]  scale_pct;
        logic        scale_write;
        logic [1:0]  term_select;
    } pps_chg_cfg_t;

    typedef struct packed {
        logic       system_on;
        logic       rail_from_adapter;
        logic       rail_from_battery;
        logic       buck_en;
        logic       digital_en;
        logic [3:0] aux_en;
    } pps_rail_t;

    typedef struct packed {
        pps_chg_mode_t mode;
        logic          charging;
        logic [10:0]   current_ma;
        logic [10:0]   term_ma;
    } pps_chg_out_t;

    function automatic logic [10:0] pps_pct_of(logic [10:0] ma, logic [7:0] pct);
        logic [18:0] prod;
        prod = 19'(ma) * 19'(pct);
        return 11'(prod / 19'd100);
    endfunction

endpackage

// file: core/pps_key_filter.sv
// Synchroniser and debouncer for the push-button key input.
`include "pps_params.svh"
module pps_key_filter
    import pps_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic tick,
    input  wire logic key_n,
    output logic      pressed,
    output logic      press
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       stable;
        logic [3:0] cnt;
        logic       press;
    } pps_kf_state_t;

    localparam logic [3:0] DEB_LAST = 4'(`PPS_DEBOUNCE_TICKS - 1);

    pps_kf_state_t st;
    pps_kf_state_t next_st;

    // A press is only reported on a debounced released-to-pressed change, so
    // a held key can never raise a second press until it has been let go.
    always_comb
    begin
        next_st       = st;
        next_st.sync1 = key_n;
        next_st.sync2 = st.sync1;
        next_st.press = 1'b0;
        if (st.sync2 == st.stable)
        begin
            next_st.cnt = 4'h0;
        end
        else if (tick)
        begin
            if (st.cnt == DEB_LAST)
            begin
                next_st.stable = st.sync2;
                next_st.cnt    = 4'h0;
                next_st.press  = ~st.sync2;
            end
            else
            begin
                next_st.cnt = st.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            st <= '{sync1: 1'b1, sync2: 1'b1, stable: 1'b1, cnt: 4'h0, press: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pressed = ~st.stable;
    assign press   = st.press;
endmodule

// file: core/pps_tick_timer.sv
// Tick counter that flags expiry after a given number of timebase ticks.
module pps_tick_timer
    import pps_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        tick,
    input  wire logic        restart,
    input  wire logic [23:0] limit,
    output logic             expired
);
    typedef struct packed {
        logic [23:0] count;
        logic        expired;
    } pps_tt_state_t;

    pps_tt_state_t st;
    pps_tt_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (restart)
        begin
            next_st.count   = 24'h000000;
            next_st.expired = 1'b0;
        end
        else if (tick && !st.expired)
        begin
            if (st.count + 24'h000001 >= limit)
            begin
                next_st.expired = 1'b1;
            end
            next_st.count = st.count + 24'h000001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            st <= '{count: 24'h000000, expired: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign expired = st.expired;
endmodule

// file: core/pps_power_sequencer.sv
// Power sequencer, supply path selection and charger mode control.
//
// Notes on behaviour
// - Adapter above 4.5V turns the system on and feeds the rail.
// - Source-select low with adapter present: rail fed from adapter regulator.
// - Source-select high or forced: battery switch feeds the rail.
// - No adapter while enabled: rail connected to battery.
// - Startup on key press, adapter above lockout, or test enable high.
// - Buck enabled first; digital regulator after buck reaches 90%.
// - Digital regulator at 90% starts 65ms timer; processor reset held low.
// - Auxiliary regulators follow their enables once started, never while off.
// - Key released before hold high, no adapter or test: shut down.
// - Core converters enabled from key OR hold.
// - Adapter start keeps system on until adapter below falling lockout.
// - Second key press while running asserts the key-event output low.
// - Below lockout, power down only with key and hold both released.
// - At power-down remaining auxiliary regulators switch off with the buck.
// - Charge only with adapter above lockout and charger enable low.
// - Battery below precondition threshold: trickle at 12% of programmed current.
// - Trickle until precondition threshold, then constant current.
// - Current scaled 40% to 180%, result limited to 100mA..1A.
// - Adapter indicator release: scale back to 100%, or fixed 100mA if USB.
// - At regulation voltage go constant voltage; end at 5/10/15/20% current.
// - Safety timeouts: 1 hour trickle, 3 hours each CC and CV.
// - From sleep resume on recharge threshold, enable cycle or adapter return.
// - Adapter indicator pulled low while adapter above 4.5V.
`include "pps_params.svh"
module pps_power_sequencer
    import pps_pkg::*;
#(
    parameter logic [15:0] TICK_CYCLES   = 16'(`PPS_TICK_CYCLES),
    parameter logic [23:0] TRICKLE_TICKS = 24'(`PPS_TRICKLE_TICKS),
    parameter logic [23:0] CCCV_TICKS    = 24'(`PPS_CCCV_TICKS)
)
(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire pps_sense_t   sense,
    input  wire pps_chg_cfg_t chg_cfg,
    output pps_rail_t         rail,
    output pps_chg_out_t      chg_out,
    output logic              cpu_reset_n,
    output logic              key_event_n,
    output logic              adapter_present_n_o,
    output logic              adapter_present_n_oe
);
    typedef struct packed {
        logic [15:0]   prescale;
        logic          tick;
        pps_seq_t      seq;
        pps_chg_mode_t chg;
        logic          chg_restart;
        logic          key_event;
        logic [7:0]    scale_pct;
        logic          usb_fixed;
        logic          prev_adapter;
        logic          prev_enable_n;
        pps_rail_t     rail;
        pps_chg_out_t  chg_out;
        logic          cpu_reset_n;
        logic          adapter_pull;
    } pps_ps_state_t;

    localparam logic [23:0] RESET_TICKS = 24'(`PPS_RESET_DELAY_TICKS);
    localparam logic [7:0]  SCALE_MIN   = 8'(`PPS_SCALE_MIN_PCT);
    localparam logic [7:0]  SCALE_MAX   = 8'(`PPS_SCALE_MAX_PCT);
    localparam logic [7:0]  SCALE_RST   = 8'(`PPS_SCALE_RESET_PCT);
    localparam logic [7:0]  TRICKLE_PCT = 8'(`PPS_TRICKLE_PCT);
    localparam logic [7:0]  TERM_STEP   = 8'(`PPS_TERM_STEP_PCT);
    localparam logic [10:0] CUR_MIN     = 11'(`PPS_CURRENT_MIN_MA);
    localparam logic [10:0] CUR_MAX     = 11'(`PPS_CURRENT_MAX_MA);
    localparam logic [10:0] USB_FIXED   = 11'(`PPS_USB_FIXED_MA);

    pps_ps_state_t st;
    pps_ps_state_t next_st;

    logic key_pressed;
    logic key_press;
    logic reset_done;
    logic chg_expired;
    logic reset_restart;
    logic [23:0] chg_limit;

    pps_key_filter u_key (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (st.tick),
        .key_n   (sense.key_n),
        .pressed (key_pressed),
        .press   (key_press)
    );

    // The delay only runs while the digital rail stays good, so a sag restarts it.
    assign reset_restart = !(st.seq == PPS_SEQ_RESET && sense.digital_good);

    pps_tick_timer u_reset_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (st.tick),
        .restart (reset_restart),
        .limit   (RESET_TICKS),
        .expired (reset_done)
    );

    assign chg_limit = (st.chg == PPS_CHG_TRICKLE) ? TRICKLE_TICKS : CCCV_TICKS;

    pps_tick_timer u_chg_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (st.tick),
        .restart (st.chg_restart),
        .limit   (chg_limit),
        .expired (chg_expired)
    );

    function automatic logic [7:0] clamp_scale(logic [7:0] pct);
        if (pct < SCALE_MIN)
        begin
            return SCALE_MIN;
        end
        else if (pct > SCALE_MAX)
        begin
            return SCALE_MAX;
        end
        return pct;
    endfunction

    always_comb
    begin
        logic adapter;
        logic want_on;
        logic on;
        logic to_battery;
        logic allowed;
        logic [10:0] cc_ma;
        logic [7:0] term_pct;
        adapter    = sense.adapter_above_uvlo;
        want_on    = key_pressed | sense.hold | adapter | sense.test_enable;
        next_st    = st;
        allowed    = adapter && !chg_cfg.charger_enable_n;
        on         = 1'b0;
        cc_ma      = 11'h000;
        to_battery = sense.source_select | sense.force_battery | !adapter;
        term_pct   = 8'(({6'h00, chg_cfg.term_select} + 8'h01) * TERM_STEP);
        next_st.tick     = (st.prescale == TICK_CYCLES - 16'h0001);
        next_st.prescale = next_st.tick ? 16'h0000 : st.prescale + 16'h0001;
        next_st.prev_adapter  = adapter;
        next_st.prev_enable_n = chg_cfg.charger_enable_n;

        // Power-up and power-down sequence.
        case (st.seq)
            PPS_SEQ_OFF:
            begin
                if (want_on)
                begin
                    next_st.seq = PPS_SEQ_BUCK_UP;
                end
            end
            PPS_SEQ_BUCK_UP:
            begin
                if (sense.buck_good)
                begin
                    next_st.seq = PPS_SEQ_DIG_UP;
                end
            end
            PPS_SEQ_DIG_UP:
            begin
                if (sense.digital_good)
                begin
                    next_st.seq = PPS_SEQ_RESET;
                end
            end
            PPS_SEQ_RESET:
            begin
                if (reset_done)
                begin
                    next_st.seq = PPS_SEQ_RUN;
                end
            end
            PPS_SEQ_RUN:
            begin
                next_st.seq = PPS_SEQ_RUN;
            end
            default:
            begin
                next_st.seq = PPS_SEQ_OFF;
            end
        endcase
        // Key and hold are OR'd; adapter or test presence vetoes shutdown.
        if (st.seq != PPS_SEQ_OFF && !want_on)
        begin
            next_st.seq = PPS_SEQ_OFF;
        end

        // The event stays asserted while the second press is held.
        if (st.seq == PPS_SEQ_RUN && key_press)
        begin
            next_st.key_event = 1'b1;
        end
        else if (!key_pressed || next_st.seq == PPS_SEQ_OFF)
        begin
            next_st.key_event = 1'b0;
        end

        on         = (next_st.seq != PPS_SEQ_OFF);
        next_st.rail.system_on         = on;
        next_st.rail.rail_from_adapter = on && !to_battery;
        next_st.rail.rail_from_battery = on && to_battery;
        next_st.rail.buck_en           = on;
        next_st.rail.digital_en        = on && next_st.seq != PPS_SEQ_BUCK_UP;
        // Aux rails drop in the same cycle as the buck at global power-down.
        next_st.rail.aux_en            = on ? sense.aux_request : 4'h0;
        next_st.cpu_reset_n            = (next_st.seq == PPS_SEQ_RUN);
        next_st.adapter_pull           = adapter;
        // Charge current programming; a write after the adapter drop lifts the override.
        if (st.prev_adapter && !adapter)
        begin
            next_st.scale_pct = SCALE_RST;
            next_st.usb_fixed = sense.source_select;
        end
        if (chg_cfg.scale_write)
        begin
            next_st.scale_pct = clamp_scale(chg_cfg.scale_pct);
            next_st.usb_fixed = 1'b0;
        end

        // Charger mode selection.
        case (st.chg)
            PPS_CHG_IDLE:
            begin
                if (allowed)
                begin
                    next_st.chg = chg_cfg.batt_above_precond ? PPS_CHG_CC : PPS_CHG_TRICKLE;
                end
            end
            PPS_CHG_TRICKLE:
            begin
                if (chg_cfg.batt_above_precond)
                begin
                    next_st.chg = PPS_CHG_CC;
                end
            end
            PPS_CHG_CC:
            begin
                if (chg_cfg.batt_at_regulation)
                begin
                    next_st.chg = PPS_CHG_CV;
                end
            end
            PPS_CHG_CV:
            begin
                if (chg_cfg.current_below_term)
                begin
                    next_st.chg = PPS_CHG_SLEEP;
                end
            end
            PPS_CHG_SLEEP, PPS_CHG_FAULT:
            begin
                // Sleep survives adapter removal; only these events wake it.
                if (chg_cfg.batt_below_recharge && st.chg == PPS_CHG_SLEEP)
                begin
                    next_st.chg = PPS_CHG_IDLE;
                end
                else if ((!st.prev_adapter && adapter) || (!st.prev_enable_n &&
                         chg_cfg.charger_enable_n))
                begin
                    next_st.chg = PPS_CHG_IDLE;
                end
            end
            default:
            begin
                next_st.chg = PPS_CHG_IDLE;
            end
        endcase
        if (st.chg inside {PPS_CHG_TRICKLE, PPS_CHG_CC, PPS_CHG_CV})
        begin
            if (!allowed)
            begin
                next_st.chg = PPS_CHG_IDLE;
            end
            else if (chg_expired && !st.chg_restart)
            begin
                next_st.chg = PPS_CHG_FAULT;
            end
        end
        next_st.chg_restart = (next_st.chg != st.chg);

        cc_ma = pps_pct_of(chg_cfg.charge_current_set_default_ma, next_st.scale_pct);
        if (cc_ma < CUR_MIN)
        begin
            cc_ma = CUR_MIN;
        end
        else if (cc_ma > CUR_MAX)
        begin
            cc_ma = CUR_MAX;
        end
        if (next_st.usb_fixed)
        begin
            cc_ma = USB_FIXED;
        end
        next_st.chg_out.mode     = next_st.chg;
        next_st.chg_out.charging = next_st.chg inside {PPS_CHG_TRICKLE, PPS_CHG_CC,
                                                       PPS_CHG_CV};
        next_st.chg_out.current_ma = (next_st.chg == PPS_CHG_TRICKLE) ?
                                     pps_pct_of(cc_ma, TRICKLE_PCT) : cc_ma;
        next_st.chg_out.term_ma  = pps_pct_of(cc_ma, term_pct);
        if (!next_st.chg_out.charging)
        begin
            next_st.chg_out.current_ma = 11'h000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            st               <= '0;
            st.seq           <= PPS_SEQ_OFF;
            st.chg           <= PPS_CHG_IDLE;
            st.scale_pct     <= 8'(`PPS_SCALE_RESET_PCT);
            st.prev_enable_n <= 1'b1;
            st.chg_restart   <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rail                 = st.rail;
    assign chg_out              = st.chg_out;
    assign cpu_reset_n          = st.cpu_reset_n;
    assign key_event_n          = ~st.key_event;
    assign adapter_present_n_o  = 1'b0;
    assign adapter_present_n_oe = st.adapter_pull;
endmodule

// file: tb/pps_power_sequencer_properties.sv
// Concurrent checks on the ports of the power sequencer.
module pps_power_sequencer_properties
    import pps_pkg::*;
#(
    parameter logic [15:0] TICK_CYCLES = 16'h0004
)
(
    input wire logic         clk_sys,
    input wire logic         reset_n,
    input wire pps_sense_t   sense,
    input wire pps_chg_cfg_t chg_cfg,
    input wire pps_rail_t    rail,
    input wire pps_chg_out_t chg_out,
    input wire logic         cpu_reset_n,
    input wire logic         key_event_n,
    input wire logic         adapter_present_n_o,
    input wire logic         adapter_present_n_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Tick alignment may cost up to one tick, so the bound allows 64 whole ticks.
    int dg_cycles;
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !sense.digital_good)
            dg_cycles <= 0;
        else if (dg_cycles < 100000)
            dg_cycles <= dg_cycles + 1;
    end

    a_oe_follows_adapter: assert property (1'b1 |=> adapter_present_n_oe == $past(sense.adapter_above_uvlo)) else $error("adapter indicator wrong");
    a_rail_source_pick: assert property (rail.system_on |-> rail.rail_from_battery != rail.rail_from_adapter && rail.rail_from_battery == $past(sense.source_select || sense.force_battery || !sense.adapter_above_uvlo)) else $error("rail source wrong");
    a_aux_off_when_down: assert property (!rail.system_on |-> rail.aux_en == 4'h0) else $error("aux enabled while off");
    a_digital_after_buck: assert property ($rose(rail.digital_en) |-> $past(sense.buck_good) && rail.buck_en) else $error("digital rail early");
    a_reset_delay_held: assert property ($rose(cpu_reset_n) |-> dg_cycles >= 64 * int'(TICK_CYCLES)) else $error("reset released early");
    a_key_event_running: assert property ($fell(key_event_n) |-> rail.system_on && cpu_reset_n) else $error("key event while not running");
    a_stay_on_adapter: assert property (rail.system_on && sense.adapter_above_uvlo |=> rail.system_on) else $error("power down with adapter");
    a_stay_on_hold: assert property (rail.system_on && (sense.hold || sense.test_enable) |=> rail.system_on) else $error("power down with hold");
    a_start_on_cause: assert property (!rail.system_on && (sense.adapter_above_uvlo || sense.hold || sense.test_enable) |=> rail.system_on && rail.buck_en) else $error("no startup");
    a_charge_allowed: assert property (chg_out.charging |-> $past(sense.adapter_above_uvlo && !chg_cfg.charger_enable_n)) else $error("charging not allowed");
endmodule

// file: tb/pps_host_model.sv
// Behavioural host processor and push-button in front of the sequencer.
module pps_host_model
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic press,
    input  wire logic hold_ok,
    input  wire logic cpu_reset_n,
    input  wire logic key_event_n,
    output logic      key_n,
    output logic      hold
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cpu_seen;

    assign key_n = !press;
    always_ff @(posedge clk_sys)
    begin
        cpu_seen <= reset_n && cpu_reset_n;
        if (!reset_n)
            hold <= 1'b0;
        else if (hold_ok && !key_event_n)
            hold <= 1'b0;
        else if (hold_ok && cpu_reset_n && !cpu_seen)
            hold <= 1'b1;
    end
endmodule

// file: tb/pps_power_sequencer_tb.sv
// Self-checking testbench of the power sequencer.
module pps_power_sequencer_tb;
    import pps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic         clk_sys, reset_n, press, hold_ok, key_n, hold;
    logic         adp, tst, ssel, fbat, bgood, dgood;
    logic [3:0]   aux;
    pps_sense_t   sense;
    pps_chg_cfg_t cfg;
    pps_rail_t    rail;
    pps_chg_out_t chg_out;
    logic         cpu_reset_n, key_event_n, oe, ind_o;
    int           miscompares, comparisons, n;
    logic [10:0]  t_charge_current_set [5] = '{11'h1F4, 11'h1F4, 11'h1F4, 11'h0C8, 11'h320};
    logic [7:0]   t_scale [5] = '{8'h14, 8'hB4, 8'hFA, 8'h28, 8'hB4};
    logic [10:0]  t_exp [5] = '{11'h0C8, 11'h384, 11'h384, 11'h064, 11'h3E8};

    assign sense = pps_sense_t'({adp, key_n, hold, tst, ssel, fbat, bgood, dgood, aux});

    pps_power_sequencer #(.TICK_CYCLES(16'h0004), .TRICKLE_TICKS(24'h000014),
        .CCCV_TICKS(24'h00001E)) pps_power_sequencer_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .sense(sense), .chg_cfg(cfg), .rail(rail), .chg_out(chg_out),
        .cpu_reset_n(cpu_reset_n), .key_event_n(key_event_n), .adapter_present_n_o(ind_o),
        .adapter_present_n_oe(oe));
    pps_host_model pps_host_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .press(press),
        .hold_ok(hold_ok), .cpu_reset_n(cpu_reset_n), .key_event_n(key_event_n),
        .key_n(key_n), .hold(hold));

    always #10 clk_sys = ~clk_sys;
    // The regulators report good 1ns after being enabled, in the same cycle.
    always @(posedge clk_sys)
    begin
        #1;
        bgood = rail.buck_en;
        dgood = rail.digital_en;
    end

    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic step(input int cycles);
        repeat (cycles) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic cond(input int k);
        case (k)
            0: return rail.buck_en;
            1: return cpu_reset_n;
            2: return !key_event_n;
            3: return !rail.system_on;
            default: return chg_out.mode == PPS_CHG_FAULT;
        endcase
    endfunction

    task automatic wait_for(input string name, input int k, input int lim, output int cnt);
        cnt = 0;
        while (cond(k) !== 1'b1 && cnt < lim)
        begin
            step(1);
            cnt++;
        end
        check(name, 32'(cond(k)), 32'h1);
    endtask

    task automatic chg(input logic [31:0] mode, input logic [31:0] cur);
        check("mode", 32'(chg_out.mode), mode);
        check("current", 32'(chg_out.current_ma), cur);
        check("charging", 32'(chg_out.charging), 32'(mode inside {32'h1, 32'h2, 32'h3}));
    endtask

    task automatic set_scale(input logic [10:0] charge_current_set, input logic [7:0] pct);
        cfg.charge_current_set_default_ma = charge_current_set;
        cfg.scale_pct = pct;
        cfg.scale_write = 1'b1;
        step(1);
        cfg.scale_write = 1'b0;
        step(2);
    endtask

    initial
    begin
        // A stuck run still ends through the verdict.
        #200000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        {clk_sys, reset_n, press, adp, tst, ssel, fbat, aux, bgood, dgood} = '0;
        hold_ok = 1'b1;
        cfg = '0;
        cfg.charger_enable_n = 1'b1;
        cfg.charge_current_set_default_ma = 11'h1F4;
        step(5);
        check("rail", 32'(rail), 32'h0);
        check("cpu_reset_n", 32'(cpu_reset_n), 32'h0);
        check("key_event_n", 32'(key_event_n), 32'h1);
        reset_n = 1'b1;
        aux = 4'hF;
        press = 1'b1;
        step(2);
        check("aux_off", 32'(rail.aux_en), 32'h0);
        wait_for("buck_en", 0, 100, n);
        step(1);
        check("on_batt", 32'(rail.rail_from_battery), 32'h1);
        check("cpu_low", 32'(cpu_reset_n), 32'h0);
        wait_for("cpu_reset", 1, 400, n);
        check("reset_delay", 32'(n >= 256), 32'h1);
        check("aux_on", 32'(rail.aux_en), 32'hF);
        step(3);
        press = 1'b0;
        step(60);
        check("held_on", 32'(rail.system_on), 32'h1);
        press = 1'b1;
        wait_for("key_event", 2, 100, n);
        step(5);
        check("key_keeps", 32'(rail.system_on), 32'h1);
        press = 1'b0;
        wait_for("off", 3, 100, n);
        check("aux_down", 32'(rail.aux_en), 32'h0);
        hold_ok = 1'b0;
        press = 1'b1;
        wait_for("buck_en", 0, 100, n);
        step(20);
        press = 1'b0;
        wait_for("short_off", 3, 100, n);
        tst = 1'b1;
        step(2);
        check("test_on", 32'(rail.system_on), 32'h1);
        tst = 1'b0;
        adp = 1'b1;
        step(12);
        check("adapter_on", 32'(rail.rail_from_adapter), 32'h1);
        check("indicator", 32'(oe), 32'h1);
        check("indicator_low", 32'(ind_o), 32'h0);
        chg(32'(PPS_CHG_IDLE), 32'h0);
        ssel = 1'b1;
        step(2);
        check("usb_batt", 32'(rail.rail_from_battery), 32'h1);
        ssel = 1'b0;
        fbat = 1'b1;
        step(2);
        check("force_batt", 32'(rail.rail_from_battery), 32'h1);
        fbat = 1'b0;
        cfg.charger_enable_n = 1'b0;
        step(2);
        chg(32'(PPS_CHG_TRICKLE), 32'h1F4 * 12 / 100);
        cfg.batt_above_precond = 1'b1;
        step(2);
        chg(32'(PPS_CHG_CC), 32'h1F4);
        for (int i = 0; i < 5; i++)
        begin
            set_scale(t_charge_current_set[i], t_scale[i]);
            check("scaled", 32'(chg_out.current_ma), 32'(t_exp[i]));
        end
        set_scale(11'h1F4, 8'h64);
        for (int k = 0; k < 4; k++)
        begin
            cfg.term_select = 2'(k);
            step(2);
            check("term", 32'(chg_out.term_ma), 32'h1F4 * 5 * (k + 1) / 100);
        end
        cfg.batt_at_regulation = 1'b1;
        step(2);
        check("cv", 32'(chg_out.mode), 32'(PPS_CHG_CV));
        cfg.current_below_term = 1'b1;
        step(2);
        check("sleep", 32'(chg_out.mode), 32'(PPS_CHG_SLEEP));
        {cfg.batt_at_regulation, cfg.current_below_term, cfg.batt_below_recharge} = 3'h1;
        step(3);
        check("recharge", 32'(chg_out.mode), 32'(PPS_CHG_CC));
        cfg.batt_below_recharge = 1'b0;
        wait_for("timeout", 4, 200, n);
        ssel = 1'b1;
        adp = 1'b0;
        step(2);
        check("indicator_off", 32'(oe), 32'h0);
        adp = 1'b1;
        step(3);
        chg(32'(PPS_CHG_CC), 32'h064);
        ssel = 1'b0;
        set_scale(11'h1F4, 8'hB4);
        adp = 1'b0;
        step(2);
        adp = 1'b1;
        step(3);
        check("scale_reset", 32'(chg_out.current_ma), 32'h1F4);
        print_verdict();
    end
endmodule

bind pps_power_sequencer pps_power_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES))
    pps_power_sequencer_properties_i (.clk_sys(clk_sys), .reset_n(reset_n), .sense(sense),
    .chg_cfg(chg_cfg), .rail(rail), .chg_out(chg_out), .cpu_reset_n(cpu_reset_n),
    .key_event_n(key_event_n), .adapter_present_n_o(adapter_present_n_o),
    .adapter_present_n_oe(adapter_present_n_oe));
